// ===== pkg/tcci_evt_if.sv
// Timer-side signals shared by the compare channels and the capture unit.
interface tcci_evt_if;
  logic clkEn;
  logic timerTick;
  logic blockMatch;
  logic [15:0] counterValue;
  modport src (output clkEn, timerTick, blockMatch, counterValue);
  modport sink (input clkEn, timerTick, blockMatch, counterValue);
endinterface : tcci_evt_if

// ===== pkg/tcci_pkg.sv
// Constants, offsets and mode helpers of the 16-bit timer register and event block.
package tcci_pkg;
  // Register offsets in I/O space.
  localparam logic [7:0] OFF_CAP_LO = 8'h26;
  localparam logic [7:0] OFF_CAP_HI = 8'h27;
  localparam logic [7:0] OFF_CMPB_LO = 8'h28;
  localparam logic [7:0] OFF_CMPB_HI = 8'h29;
  localparam logic [7:0] OFF_CMPA_LO = 8'h2a;
  localparam logic [7:0] OFF_CMPA_HI = 8'h2b;
  localparam logic [7:0] OFF_CNT_LO = 8'h2c;
  localparam logic [7:0] OFF_CNT_HI = 8'h2d;
  localparam logic [7:0] OFF_FLAGS = 8'h38;
  localparam logic [7:0] OFF_ENABLES = 8'h39;
  // Address windows.
  localparam logic [7:0] IO_TOP = 8'h3f;
  localparam logic [7:0] DATA_BIAS = 8'h20;
  // Owned field of the shared flag and enable registers, bits 5 down to 2.
  localparam int OWN_LSB = 2;
  localparam int OWN_MSB = 5;
  // Index of each event inside the owned 4-bit field.
  localparam int EV_CAP = 3;
  localparam int EV_CMPA = 2;
  localparam int EV_CMPB = 1;
  localparam int EV_OVF = 0;
  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_EVENTS = 4'h0;

  // Where the overflow flag is raised for a waveform mode.
  typedef enum {OVF_AT_MAX, OVF_AT_TOP, OVF_AT_BOTTOM, OVF_NONE} tcci_ovf_t;

  // Modes that take the capture register as TOP.
  function automatic logic capIsTop(input logic [3:0] mode);
    capIsTop = (mode == 4'h8) || (mode == 4'ha) || (mode == 4'hc) || (mode == 4'he);
  endfunction : capIsTop

  function automatic tcci_ovf_t ovfPoint(input logic [3:0] mode);
    unique case (mode)
      4'h0, 4'h4, 4'hc: ovfPoint = OVF_AT_MAX;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: ovfPoint = OVF_AT_TOP;
      4'hd: ovfPoint = OVF_NONE;
      default: ovfPoint = OVF_AT_BOTTOM;
    endcase
  endfunction : ovfPoint
endpackage : tcci_pkg

// ===== rtl/tcci_capture.sv
// Capture unit: source select, edge detection and counter snapshot.
module tcci_capture (
  input wire logic clk_sys,
  input wire logic rst_b,
  tcci_evt_if.sink evt,
  input wire logic captureInputPin,
  input wire logic comparatorOut,
  input wire logic useComparator,
  input wire logic captureEdgeSelect,
  input wire logic captureIsTop,
  output logic captureEvent,
  output logic [15:0] captureWord
);
  logic prev_ff, nxt_prev;
  logic event_ff, nxt_event;
  logic [15:0] word_ff, nxt_word;
  logic src, edgeHit;

  // The pin is disconnected while the capture register serves as TOP.
  always_comb begin
    src = useComparator ? comparatorOut : captureInputPin; // R05
    edgeHit = captureEdgeSelect ? (src && !prev_ff) : (!src && prev_ff); // R20
    nxt_prev = src;
    nxt_event = edgeHit && !captureIsTop; // R06
    nxt_word = nxt_event ? evt.counterValue : word_ff; // R05
  end

  // A pin held high through reset shows a rising edge once; software should clear the flag.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_ff <= 1'b0;
      event_ff <= 1'b0;
      word_ff <= tcci_pkg::RST_WORD;
    end else if (evt.clkEn) begin
      prev_ff <= nxt_prev;
      event_ff <= nxt_event;
      word_ff <= nxt_word;
    end
  end

  assign captureEvent = event_ff;
  assign captureWord = word_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_cap_copy_count: assert property (evt.clkEn && edgeHit && !captureIsTop |=> captureEvent && // R05
    captureWord == $past(evt.counterValue)) else $error("capture did not copy the counter");
  a_top_disconnect: assert property (evt.clkEn && captureIsTop |=> !captureEvent) // R06
    else $error("capture fired while used as TOP");
  a_edge_polarity: assert property (evt.clkEn && !captureEdgeSelect && src && !prev_ff |=> // R20
    !captureEvent) else $error("rising edge captured in falling mode");
endmodule : tcci_capture

// ===== rtl/tcci_compare.sv
// One compare channel: match detection, delayed flag pulse and waveform strobe.
module tcci_compare (
  input wire logic clk_sys,
  input wire logic rst_b,
  tcci_evt_if.sink evt,
  input wire logic [15:0] compareValue,
  input wire logic forceStrobe,
  output logic flagSet,
  output logic waveMatch
);
  logic seen_ff, nxt_seen;
  logic hit_ff, nxt_hit;
  logic wave_ff, nxt_wave;

  // The equality is sampled on each timer tick and flagged on the next tick.
  always_comb begin
    nxt_seen = seen_ff;
    nxt_hit = 1'b0;
    if (evt.timerTick) begin
      nxt_hit = seen_ff; // R13
      nxt_seen = !evt.blockMatch && (evt.counterValue == compareValue); // R01
    end
    nxt_wave = nxt_hit | forceStrobe; // R02 R14
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seen_ff <= 1'b0;
      hit_ff <= 1'b0;
      wave_ff <= 1'b0;
    end else if (evt.clkEn) begin
      seen_ff <= nxt_seen;
      hit_ff <= nxt_hit;
      wave_ff <= nxt_wave;
    end
  end

  assign flagSet = hit_ff;
  assign waveMatch = wave_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_match_each_tick: assert property (evt.clkEn && evt.timerTick && !evt.blockMatch && // R01
    evt.counterValue == compareValue |=> seen_ff) else $error("match not seen on tick");
  a_flag_next_tick: assert property (evt.clkEn && evt.timerTick && seen_ff |=> // R13
    flagSet && waveMatch) else $error("flag not set on the following tick");
  a_force_no_flag: assert property (evt.clkEn && forceStrobe && !(evt.timerTick && seen_ff) |=> // R14
    waveMatch && !flagSet) else $error("forced strobe misbehaved");
endmodule : tcci_compare

// ===== rtl/tcci_top.sv
// Register side of the 16-bit timer: byte access, compare, capture and event flags.
// Overview of operation
// [R01] Both compare values are checked against the counter on every timer tick; a counter write blocks the check on the next tick.
// [R02] A match drives the compare flag and the waveform strobe to the pin logic.
// [R03] Compare writes load both bytes at once through one shared high-byte latch.
// [R04] Capture reads give a coherent pair, the high byte via the shared latch.
// [R05] A qualified pin or comparator event copies the counter into the capture register.
// [R06] In TOP modes the capture register is a software period register.
// [R07] Capture request needs enable bit 5, global enable and capture flag.
// [R08] Compare A request needs enable bit 4, global enable and its flag.
// [R09] Compare B request needs enable bit 3, global enable and its flag.
// [R10] Overflow request needs enable bit 2, global enable and its flag.
// [R11] A capture event on the pin sets flag bit 5.
// [R12] In capture-as-TOP modes the flag sets when the counter reaches TOP.
// [R13] Compare flags 4 and 3 set on the timer tick after equality.
// [R14] Forced compare strobes reach the output but never set a flag.
// [R15] Overflow flag 2 sets at MAX in normal and clear modes, else per mode.
// [R16] Executing a timer vector clears its flag.
// [R17] Writing one to a flag bit clears it.
// [R18] Only bits 5 to 2 of the shared registers belong to this timer.
// [R19] I/O accesses use offsets in 0x00-0x3f, data-space accesses add 0x20.
// [R20] Edge select zero captures falling edges, one captures rising edges.
// [R21] High write loads the latch, low write commits, low read fills the latch.
// [R22] Writing zero keeps a flag, and a set beats a simultaneous clear.
module tcci_top (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic ioSel,
  input wire logic dataSel,
  input wire logic [7:0] busAddr,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic [7:0] busWrData,
  output logic [7:0] busRdData,
  input wire logic [15:0] counterValue,
  input wire logic timerTick,
  input wire logic counterAtTop,
  input wire logic counterAtMax,
  input wire logic counterAtBottom,
  input wire logic [3:0] waveformModeSelect,
  input wire logic captureEdgeSelect,
  input wire logic captureFromComparator,
  input wire logic comparatorOut,
  input wire logic captureInputPin,
  input wire logic globalIrqEnable,
  input wire logic [3:0] vectorAck,
  input wire logic [1:0] forceCompare,
  output logic [3:0] irqRequest,
  output logic [1:0] compareMatch,
  output logic counterLoad,
  output logic [15:0] counterLoadValue,
  output logic [15:0] captureValue
);
  logic [7:0] latch_ff, nxt_latch;
  logic [15:0] cap_ff, nxt_cap;
  logic [15:0] cmpA_ff, nxt_cmpA;
  logic [15:0] cmpB_ff, nxt_cmpB;
  logic [3:0] flags_ff, nxt_flags;
  logic [3:0] enables_ff, nxt_enables;
  logic [3:0] irq_ff, nxt_irq;
  logic [7:0] rd_ff, nxt_rd;
  logic load_ff, nxt_load;
  logic [15:0] loadVal_ff, nxt_loadVal;
  logic block_ff, nxt_block;
  logic [7:0] off;
  logic hit, wr, rd, wrFlags, capTop, capEvent, ovfSet;
  logic [15:0] capWord;
  logic [1:0] cmpHit, waveHit;
  logic [3:0] setEv, clrEv;
  logic [15:0] cmpVal [2];

  tcci_evt_if evt ();

  assign evt.clkEn = clkEn;
  assign evt.timerTick = timerTick;
  assign evt.blockMatch = block_ff;
  assign evt.counterValue = counterValue;
  assign cmpVal[0] = cmpA_ff;
  assign cmpVal[1] = cmpB_ff;

  // One compare channel per compare register; index 0 is channel A.
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    tcci_compare u_cmp (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .evt(evt),
      .compareValue(cmpVal[i]),
      .forceStrobe(forceCompare[i]),
      .flagSet(cmpHit[i]),
      .waveMatch(waveHit[i])
    );
  end

  tcci_capture u_cap (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .evt(evt),
    .captureInputPin(captureInputPin),
    .comparatorOut(comparatorOut),
    .useComparator(captureFromComparator),
    .captureEdgeSelect(captureEdgeSelect),
    .captureIsTop(capTop),
    .captureEvent(capEvent),
    .captureWord(capWord)
  );

  // Address decode; both windows fold onto the same I/O offsets.
  always_comb begin
    off = ioSel ? busAddr : busAddr - tcci_pkg::DATA_BIAS; // R19
    hit = ioSel ? (busAddr <= tcci_pkg::IO_TOP) : // R19
      (dataSel && busAddr >= tcci_pkg::DATA_BIAS && busAddr <= tcci_pkg::IO_TOP + tcci_pkg::DATA_BIAS);
    wr = busWr && hit;
    rd = busRd && hit;
    wrFlags = wr && off == tcci_pkg::OFF_FLAGS;
    capTop = tcci_pkg::capIsTop(waveformModeSelect);
  end

  // Overflow point follows the waveform mode; the reserved mode never raises it.
  always_comb begin
    unique case (tcci_pkg::ovfPoint(waveformModeSelect))
      tcci_pkg::OVF_AT_MAX: ovfSet = timerTick && counterAtMax; // R15
      tcci_pkg::OVF_AT_TOP: ovfSet = timerTick && counterAtTop; // R15
      tcci_pkg::OVF_AT_BOTTOM: ovfSet = timerTick && counterAtBottom; // R15
      tcci_pkg::OVF_NONE: ovfSet = 1'b0;
    endcase
  end

  // Event sources and clear sources of the owned flag field.
  always_comb begin
    setEv[tcci_pkg::EV_CAP] = capTop ? (timerTick && counterAtTop) : capEvent; // R11 R12
    setEv[tcci_pkg::EV_CMPA] = cmpHit[0]; // R13
    setEv[tcci_pkg::EV_CMPB] = cmpHit[1]; // R13
    setEv[tcci_pkg::EV_OVF] = ovfSet; // R15
    clrEv = vectorAck; // R16
    if (wrFlags) begin
      clrEv = vectorAck | busWrData[tcci_pkg::OWN_MSB:tcci_pkg::OWN_LSB]; // R17 R18
    end
  end

  // Register file next state. Compare reads bypass the latch since their values never move.
  always_comb begin
    nxt_latch = latch_ff;
    nxt_cap = capEvent ? capWord : cap_ff; // R05
    nxt_cmpA = cmpA_ff;
    nxt_cmpB = cmpB_ff;
    nxt_enables = enables_ff;
    nxt_load = 1'b0;
    nxt_loadVal = loadVal_ff;
    nxt_rd = tcci_pkg::RST_BYTE;
    nxt_block = timerTick ? 1'b0 : block_ff;
    // A set beats a clear in the same cycle so no event is lost.
    nxt_flags = (flags_ff & ~clrEv) | setEv; // R22
    nxt_irq = enables_ff & flags_ff & {4{globalIrqEnable}}; // R07 R08 R09 R10
    if (wr) begin
      unique case (off)
        tcci_pkg::OFF_CAP_HI, tcci_pkg::OFF_CMPA_HI, tcci_pkg::OFF_CMPB_HI, tcci_pkg::OFF_CNT_HI: begin
          nxt_latch = busWrData; // R21
        end
        tcci_pkg::OFF_CAP_LO: nxt_cap = {latch_ff, busWrData}; // R06 R21
        tcci_pkg::OFF_CMPA_LO: nxt_cmpA = {latch_ff, busWrData}; // R03
        tcci_pkg::OFF_CMPB_LO: nxt_cmpB = {latch_ff, busWrData}; // R03
        tcci_pkg::OFF_CNT_LO: begin
          nxt_load = 1'b1;
          nxt_loadVal = {latch_ff, busWrData};
          nxt_block = 1'b1;
        end
        tcci_pkg::OFF_ENABLES: nxt_enables = busWrData[tcci_pkg::OWN_MSB:tcci_pkg::OWN_LSB]; // R18
        default: ;
      endcase
    end
    if (rd) begin
      unique case (off)
        tcci_pkg::OFF_CAP_LO: begin
          nxt_rd = cap_ff[7:0]; // R04
          nxt_latch = cap_ff[15:8]; // R04 R21
        end
        tcci_pkg::OFF_CNT_LO: begin
          nxt_rd = counterValue[7:0];
          nxt_latch = counterValue[15:8]; // R21
        end
        tcci_pkg::OFF_CAP_HI, tcci_pkg::OFF_CNT_HI: nxt_rd = latch_ff; // R04
        tcci_pkg::OFF_CMPA_LO: nxt_rd = cmpA_ff[7:0];
        tcci_pkg::OFF_CMPA_HI: nxt_rd = cmpA_ff[15:8];
        tcci_pkg::OFF_CMPB_LO: nxt_rd = cmpB_ff[7:0];
        tcci_pkg::OFF_CMPB_HI: nxt_rd = cmpB_ff[15:8];
        tcci_pkg::OFF_FLAGS: nxt_rd = {2'b00, flags_ff, 2'b00}; // R18
        tcci_pkg::OFF_ENABLES: nxt_rd = {2'b00, enables_ff, 2'b00}; // R18
        default: ;
      endcase
    end
  end

  // All state holds while the clock enable is low.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      latch_ff <= tcci_pkg::RST_BYTE;
      cap_ff <= tcci_pkg::RST_WORD;
      cmpA_ff <= tcci_pkg::RST_WORD;
      cmpB_ff <= tcci_pkg::RST_WORD;
      flags_ff <= tcci_pkg::RST_EVENTS;
      enables_ff <= tcci_pkg::RST_EVENTS;
      irq_ff <= tcci_pkg::RST_EVENTS;
      rd_ff <= tcci_pkg::RST_BYTE;
      load_ff <= 1'b0;
      loadVal_ff <= tcci_pkg::RST_WORD;
      block_ff <= 1'b0;
    end else if (clkEn) begin
      latch_ff <= nxt_latch;
      cap_ff <= nxt_cap;
      cmpA_ff <= nxt_cmpA;
      cmpB_ff <= nxt_cmpB;
      flags_ff <= nxt_flags;
      enables_ff <= nxt_enables;
      irq_ff <= nxt_irq;
      rd_ff <= nxt_rd;
      load_ff <= nxt_load;
      loadVal_ff <= nxt_loadVal;
      block_ff <= nxt_block;
    end
  end

  assign busRdData = rd_ff;
  assign irqRequest = irq_ff;
  assign compareMatch = waveHit; // R02
  assign counterLoad = load_ff;
  assign counterLoadValue = loadVal_ff;
  assign captureValue = cap_ff; // R06

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // A frozen cycle holds the request, so only requests registered on an enabled edge are judged.
  a_cap_irq_gate: assert property ($past(clkEn) && irqRequest[3] |-> $past(enables_ff[3] && flags_ff[3] && // R07
    globalIrqEnable)) else $error("capture request without enable");
  a_cmpa_irq_gate: assert property ($past(clkEn) && irqRequest[2] |-> $past(enables_ff[2] && globalIrqEnable)) // R08
    else $error("compare A request without enable");
  a_cmpb_irq_gate: assert property ($past(clkEn) && irqRequest[1] |-> $past(enables_ff[1] && globalIrqEnable)) // R09
    else $error("compare B request without enable");
  a_ovf_irq_raise: assert property (clkEn && enables_ff[0] && flags_ff[0] && globalIrqEnable |=> // R10
    irqRequest[0]) else $error("overflow request missing");
  a_cmp_pair_write: assert property (clkEn && wr && off == tcci_pkg::OFF_CMPA_LO |=> // R03
    cmpA_ff == {$past(latch_ff), $past(busWrData)}) else $error("compare A pair not committed");
  a_high_only_latch: assert property (clkEn && wr && off == tcci_pkg::OFF_CMPB_HI |=> // R21
    $stable(cmpB_ff) && latch_ff == $past(busWrData)) else $error("high write leaked");
  a_cap_read_pair: assert property (clkEn && rd && off == tcci_pkg::OFF_CAP_LO && !capEvent |=> // R04
    busRdData == $past(cap_ff[7:0]) && latch_ff == $past(cap_ff[15:8])) else $error("capture pair split");
  a_flag_w1c: assert property (clkEn && wrFlags && busWrData[5] && !setEv[3] |=> !flags_ff[3]) // R17
    else $error("flag not cleared by one");
  a_set_beats_clear: assert property (clkEn && setEv[2] |=> flags_ff[2]) // R22
    else $error("flag set lost");
  a_vector_clears: assert property (clkEn && vectorAck[1] && !setEv[1] |=> !flags_ff[1]) // R16
    else $error("vector did not clear flag");
  a_decode_window: assert property (clkEn && busRd && dataSel && !ioSel && busAddr < tcci_pkg::DATA_BIAS // R19
    |=> busRdData == tcci_pkg::RST_BYTE) else $error("data space below window answered");

  // Flag set sources; every event shows in its flag one cycle later.
  a_cap_pin_flag: assert property (clkEn && !capTop && capEvent |=> flags_ff[3]) // R11
    else $error("capture event did not set its flag");
  a_cap_top_flag: assert property (clkEn && capTop && timerTick && counterAtTop |=> flags_ff[3]) // R12
    else $error("TOP did not set the capture flag");
  a_top_no_pin: assert property (clkEn && capTop && !(timerTick && counterAtTop) && !flags_ff[3] |=> !flags_ff[3]) // R12
    else $error("capture flag set off TOP");
  a_cmpa_flag_set: assert property (clkEn && cmpHit[0] |=> flags_ff[2]) // R13
    else $error("compare A flag not set");
  a_cmpb_flag_set: assert property (clkEn && cmpHit[1] |=> flags_ff[1]) // R13
    else $error("compare B flag not set");
  a_cmp_quiet: assert property (clkEn && !cmpHit[0] && !flags_ff[2] |=> !flags_ff[2]) // R14
    else $error("compare A flag set without a match");
  a_ovf_max_mode: assert property (clkEn && waveformModeSelect == 4'h0 && timerTick && counterAtMax |=> flags_ff[0]) // R15
    else $error("overflow at MAX missed");
  a_ovf_bottom_mode: assert property (clkEn && waveformModeSelect == 4'h1 && timerTick && counterAtBottom // R15
    |=> flags_ff[0]) else $error("overflow at BOTTOM missed");
  a_ovf_quiet: assert property (clkEn && !ovfSet && !flags_ff[0] |=> !flags_ff[0]) // R15
    else $error("overflow flag set without its event");
  a_reserved_no_ovf: assert property (clkEn && waveformModeSelect == 4'hd && !flags_ff[0] |=> !flags_ff[0]) // R15
    else $error("reserved mode raised overflow");

  // Flag clears and the request gate.
  a_ovf_w1c: assert property (clkEn && wrFlags && busWrData[2] && !setEv[0] |=> !flags_ff[0]) // R17
    else $error("overflow flag not cleared by one");
  a_zero_keeps: assert property (clkEn && wrFlags && !busWrData[4] && !vectorAck[2] && flags_ff[2] |=> flags_ff[2]) // R22
    else $error("writing zero cleared a flag");
  a_vector_cap: assert property (clkEn && vectorAck[3] && !setEv[3] |=> !flags_ff[3]) // R16
    else $error("capture vector did not clear flag");
  a_no_irq_masked: assert property (clkEn && !globalIrqEnable |=> irqRequest == 4'h0) // R07 R08 R09 R10
    else $error("request with global enable low");

  // Register bus side: owned bits, decode and the shared latch.
  a_enable_owned: assert property (clkEn && wr && off == tcci_pkg::OFF_ENABLES |=> // R18
    enables_ff == $past(busWrData[5:2])) else $error("enable write took foreign bits");
  a_flag_read_bits: assert property (clkEn && rd && off == tcci_pkg::OFF_FLAGS |=> // R18
    busRdData[7:6] == 2'b00 && busRdData[1:0] == 2'b00) else $error("foreign flag bits read back");
  a_idle_read_zero: assert property (clkEn && !rd |=> busRdData == tcci_pkg::RST_BYTE) // R19
    else $error("read data without a read");
  a_data_hit: assert property (clkEn && busRd && !ioSel && dataSel && busAddr == tcci_pkg::OFF_FLAGS + // R19
    tcci_pkg::DATA_BIAS |=> busRdData == {2'b00, $past(flags_ff), 2'b00}) else $error("data space read missed");
  a_cmpb_pair: assert property (clkEn && wr && off == tcci_pkg::OFF_CMPB_LO |=> // R03
    cmpB_ff == {$past(latch_ff), $past(busWrData)}) else $error("compare B pair not committed");
  a_cap_hi_read: assert property (clkEn && rd && off == tcci_pkg::OFF_CAP_HI |=> busRdData == $past(latch_ff)) // R04
    else $error("capture high byte not from latch");
  a_cnt_load: assert property (clkEn && wr && off == tcci_pkg::OFF_CNT_LO |=> counterLoad && // R21
    counterLoadValue == {$past(latch_ff), $past(busWrData)}) else $error("counter load pair wrong");
  a_cap_snapshot: assert property (clkEn && capEvent && !(wr && off == tcci_pkg::OFF_CAP_LO) |=> // R05
    captureValue == $past(capWord)) else $error("capture snapshot not stored");
endmodule : tcci_top

// ===== sim/tcci_cnt_model.sv
// Counter unit model that feeds the timer register block.
module tcci_cnt_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic runEn,
  input wire logic counterLoad,
  input wire logic [15:0] counterLoadValue,
  input wire logic [15:0] topValue,
  output logic [15:0] counterValue,
  output logic timerTick,
  output logic atTop,
  output logic atMax,
  output logic atBottom
);
  timeunit 1ns;
  timeprecision 100ps;
  // A processor load wins over counting, so a write never races a tick.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      counterValue <= 16'h0000;
      timerTick <= 1'b0;
    end else begin
      timerTick <= runEn;
      if (counterLoad) counterValue <= counterLoadValue;
      else if (timerTick) counterValue <= counterValue + 16'h0001;
    end
  end
  // Position flags are plain decodes; the model never clears at TOP, a limitation.
  assign atTop = (counterValue == topValue);
  assign atMax = (counterValue == 16'hffff);
  assign atBottom = (counterValue == 16'h0000);
endmodule : tcci_cnt_model

// ===== sim/test_timer16_compare_capture_irq.sv
// Self-checking bench of the 16-bit timer register block.
module test_timer16_compare_capture_irq;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ioSel = 1'b0, dataSel = 1'b0, busWr = 1'b0, busRd = 1'b0, runEn = 1'b0, clkEn = 1'b1;
  logic edgeSel = 1'b0, fromCmp = 1'b0, cmpOut = 1'b0, pin = 1'b0, gie = 1'b0;
  logic [7:0] busAddr = 8'h00, busWrData = 8'h00, busRdData;
  logic [3:0] mode = 4'h0, vack = 4'h0, irqRequest;
  logic [1:0] forceCmp = 2'h0, compareMatch;
  int pulseA = 0;
  int pulseB = 0;
  logic counterLoad, timerTick, atTop, atMax, atBottom;
  logic [15:0] counterLoadValue, captureValue, counterValue;
  int num_errors = 0;
  int total_checks = 0;

  always #12.5 clk_sys = ~clk_sys;
  // Strobe counters, because a one-cycle pulse is easy to miss between checks.
  always @(posedge clk_sys) begin
    if (compareMatch[0] === 1'b1) pulseA <= pulseA + 1;
    if (compareMatch[1] === 1'b1) pulseB <= pulseB + 1;
  end

  tcci_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn), .ioSel(ioSel), .dataSel(dataSel),
    .busAddr(busAddr), .busWr(busWr), .busRd(busRd), .busWrData(busWrData), .busRdData(busRdData),
    .counterValue(counterValue), .timerTick(timerTick), .counterAtTop(atTop), .counterAtMax(atMax),
    .counterAtBottom(atBottom), .waveformModeSelect(mode), .captureEdgeSelect(edgeSel),
    .captureFromComparator(fromCmp), .comparatorOut(cmpOut), .captureInputPin(pin),
    .globalIrqEnable(gie), .vectorAck(vack), .forceCompare(forceCmp), .irqRequest(irqRequest),
    .compareMatch(compareMatch), .counterLoad(counterLoad), .counterLoadValue(counterLoadValue),
    .captureValue(captureValue));

  tcci_cnt_model cnt (.clk_sys(clk_sys), .rst_b(rst_b), .runEn(runEn), .counterLoad(counterLoad),
    .counterLoadValue(counterLoadValue), .topValue(captureValue), .counterValue(counterValue),
    .timerTick(timerTick), .atTop(atTop), .atMax(atMax), .atBottom(atBottom));

  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Offsets above the I/O window are sent as data-space accesses.
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_sys);
    ioSel = (a <= 8'h3f);
    dataSel = (a > 8'h3f);
    busAddr = a;
    busWrData = d;
    busWr = w;
    busRd = ~w;
    @(negedge clk_sys);
    busWr = 1'b0;
    busRd = 1'b0;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(a, d, 1'b1);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    acc(a, 8'h00, 1'b0);
    chk(16'(busRdData), 16'(exp));
  endtask : rdChk

  // High byte first, so the low write commits the pair.
  task automatic wr16(input logic [7:0] hiAddr, input logic [15:0] v);
    wr(hiAddr, v[15:8]);
    wr(hiAddr - 8'h01, v[7:0]);
  endtask : wr16

  task automatic waitIrq(input int b);
    int n;
    for (n = 0; n < 2000 && irqRequest[b] !== 1'b1; n++) @(negedge clk_sys);
    if (n == 2000) begin
      num_errors++;
      stop_test();
    end
  endtask : waitIrq

  task automatic resetRegs();
    for (int a = 8'h26; a <= 8'h2b; a++) rdChk(8'(a), 8'h00);
    rdChk(8'h38, 8'h00);
    rdChk(8'h39, 8'h00);
    rdChk(8'h30, 8'h00);
  endtask : resetRegs

  task automatic pairAccess();
    wr16(8'h2b, 16'h1234);
    rdChk(8'h2a, 8'h34);
    rdChk(8'h2b, 8'h12);
    wr16(8'h49, 16'habcd);
    rdChk(8'h28, 8'hcd);
    rdChk(8'h29, 8'hab);
    wr(8'h6a, 8'h55);
    rdChk(8'h2a, 8'h34);
    wr16(8'h27, 16'h5a6b);
    rdChk(8'h26, 8'h6b);
    rdChk(8'h27, 8'h5a);
    wr(8'h39, 8'hff);
    rdChk(8'h39, 8'h3c);
    // A write offered while the clock enable is low must not land.
    clkEn = 1'b0;
    wr(8'h39, 8'h00);
    clkEn = 1'b1;
    rdChk(8'h39, 8'h3c);
  endtask : pairAccess

  task automatic compareRun();
    int a0;
    int b0;
    wr(8'h39, 8'h18);
    gie = 1'b1;
    wr16(8'h2b, 16'h0010);
    wr16(8'h29, 16'h0018);
    wr16(8'h2d, 16'h0000);
    a0 = pulseA;
    b0 = pulseB;
    runEn = 1'b1;
    waitIrq(2);
    chk(16'(pulseA - a0), 16'h0001);
    chk(16'(pulseB - b0), 16'h0000);
    waitIrq(1);
    runEn = 1'b0;
    rdChk(8'h38, 8'h18);
    wr(8'h38, 8'h10);
    rdChk(8'h38, 8'h08);
    chk(16'(irqRequest), 16'h0002);
    @(negedge clk_sys);
    vack = 4'h2;
    @(negedge clk_sys);
    vack = 4'h0;
    rdChk(8'h38, 8'h00);
  endtask : compareRun

  task automatic forceStrobe();
    int a0;
    int b0;
    a0 = pulseA;
    b0 = pulseB;
    forceCmp = 2'h3;
    @(negedge clk_sys);
    forceCmp = 2'h0;
    repeat (3) @(negedge clk_sys);
    chk(16'(pulseA - a0), 16'h0001);
    chk(16'(pulseB - b0), 16'h0001);
    rdChk(8'h38, 8'h00);
  endtask : forceStrobe

  task automatic captureEdge();
    gie = 1'b0;
    wr(8'h39, 8'h20);
    wr16(8'h2d, 16'h4321);
    pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    rdChk(8'h38, 8'h00);
    pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(captureValue, 16'h4321);
    rdChk(8'h38, 8'h20);
    chk(16'(irqRequest), 16'h0000);
    gie = 1'b1;
    waitIrq(3);
    wr(8'h38, 8'h20);
    edgeSel = 1'b1;
    fromCmp = 1'b1;
    wr16(8'h2d, 16'h0777);
    // The load lands one edge after the write, and the snapshot takes the pre-edge count.
    @(negedge clk_sys);
    cmpOut = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(captureValue, 16'h0777);
  endtask : captureEdge

  task automatic topAndOverflow();
    wr(8'h38, 8'h3c);
    mode = 4'hc;
    wr16(8'h27, 16'h0040);
    wr16(8'h2d, 16'h0000);
    wr(8'h39, 8'h24);
    runEn = 1'b1;
    waitIrq(3);
    runEn = 1'b0;
    chk(captureValue, 16'h0040);
    // Counting up to TOP passes both compare values as well.
    rdChk(8'h38, 8'h38);
    wr(8'h38, 8'h3c);
    wr16(8'h2d, 16'hfff0);
    runEn = 1'b1;
    waitIrq(0);
    runEn = 1'b0;
    rdChk(8'h38, 8'h04);
    wr(8'h38, 8'h3c);
    mode = 4'he;
    wr16(8'h2d, 16'h0030);
    runEn = 1'b1;
    waitIrq(0);
    runEn = 1'b0;
    rdChk(8'h38, 8'h24);
  endtask : topAndOverflow

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    resetRegs();
    pairAccess();
    compareRun();
    forceStrobe();
    captureEdge();
    topAndOverflow();
    stop_test();
  end
endmodule : test_timer16_compare_capture_irq
